// File: inc/usdp_pkg.sv
// Package with register map, field layout and carrier types of the shadow data port.
package usdp_pkg;

  localparam logic [31:0] USDP_BASE_ADDR     = 32'h5000_1100;
  localparam logic [31:0] USDP_SHADOW0_ADDR  = 32'h5000_1130;
  localparam logic [31:0] USDP_SHADOW5_ADDR  = 32'h5000_1144;
  localparam logic [31:0] USDP_SHADOW6_ADDR  = 32'h5000_1148;
  localparam int          USDP_SHADOW_COUNT  = 16;
  localparam logic [31:0] USDP_DATA_ADDR     = 32'h5000_1100;
  localparam logic [31:0] USDP_CTRL_ADDR     = 32'h5000_1108;
  localparam logic [31:0] USDP_STATUS_ADDR   = 32'h5000_1114;
  localparam logic [31:0] USDP_IRQ_STAT_ADDR = 32'h5000_1180;
  localparam logic [31:0] USDP_IRQ_MASK_ADDR = 32'h5000_1184;

  localparam int          USDP_CHAR_MSB      = 7;
  localparam logic [7:0]  USDP_CHAR_RESET    = 8'h00;
  localparam int          USDP_CTRL_FIFO_EN  = 0;
  localparam int          USDP_CTRL_IR_MODE  = 1;
  localparam int          USDP_STAT_DREADY   = 0;
  localparam int          USDP_STAT_OVERRUN  = 1;
  localparam int          USDP_STAT_THEMPTY  = 5;
  localparam int          USDP_STAT_TEMT     = 6;
  localparam int          USDP_IRQ_OVERRUN   = 0;
  localparam int          USDP_IRQ_TXLOST    = 1;
  localparam int          USDP_IRQ_RXREADY   = 2;
  localparam int          USDP_IRQ_THEMPTY   = 3;
  localparam logic [3:0]  USDP_IRQ_RESET     = 4'h0;
  localparam int          USDP_FIFO_DEPTH    = 16;

  // Character passing between the line side and the data port.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } usdp_char_s;

  // Classic Wishbone request from the master.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } usdp_wb_req_s;

endpackage : usdp_pkg

// File: rtl/usdp_top.sv
// Shadow data port of a UART: receive buffer or FIFO, transmit holding or FIFO.
// Behaviour
// - Sixteen word aliases map the receive buffer.
// - Read returns byte from serial or infrared input.
// - FIFOs off: new character overwrites, overrun flagged.
// - FIFOs on: read returns receive FIFO head.
// - Full receive FIFO keeps contents, drops, overruns.
// - Write sends character on serial or infrared output.
// - FIFOs off: one write clears holding-empty flag.
// - FIFOs off: further write overwrites pending character.
// - FIFOs on: accept writes until transmit FIFO full.
// - Write into full transmit FIFO is discarded.
// - Data field bits 7:0, read/write, resets zero.
//
// Register access over Wishbone was decided locally.
module usdp_top
  import usdp_pkg::*;
#(
  parameter int DEPTH = usdp_pkg::USDP_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave.
  input  wire usdp_pkg::usdp_wb_req_s wb_req_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  // Character from the receiver serialiser.
  input  wire usdp_pkg::usdp_char_s rx_char_i,
  input  wire usdp_pkg::usdp_char_s ir_rx_char_i,
  // Character to the transmitter serialiser.
  input  wire logic                 tx_take_i,
  output usdp_pkg::usdp_char_s      tx_char_o,
  output logic                      ir_mode_o,
  // Interrupt.
  output logic                      irq_o
);
  import usdp_pkg::*;

  localparam int            AW       = $clog2(DEPTH);
  localparam logic [AW:0]   FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH-1);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and state.
  logic [7:0]    rx_mem [DEPTH];
  logic [7:0]    tx_mem [DEPTH];
  logic [AW-1:0] rx_rd_r;
  logic [AW-1:0] rx_wr_r;
  logic [AW-1:0] tx_rd_r;
  logic [AW-1:0] tx_wr_r;
  logic [AW:0]   rx_cnt_r;
  logic [AW:0]   tx_cnt_r;
  logic [7:0]    rx_hold_r;
  logic [7:0]    tx_hold_r;
  logic          rx_full1_r;
  logic          tx_full1_r;
  logic          fifo_en_r;
  logic          ir_mode_r;
  logic          overrun_r;
  logic [3:0]    irq_stat_r;
  logic [3:0]    irq_mask_r;
  logic [31:0]   wb_dat_r;
  logic          wb_ack_r;
  usdp_char_s    tx_out_r;
  logic          irq_r;
  logic          ir_mode_o_r;

  ////////////////////////////////////////////////////////////////////////////
  // Register word packing; every field sits at its package position.
  function automatic logic [31:0] pack_ctrl(input logic fifo_en, input logic ir_mode);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[USDP_CTRL_FIFO_EN] = fifo_en;
    w[USDP_CTRL_IR_MODE] = ir_mode;
    return w;
  endfunction : pack_ctrl

  function automatic logic [31:0] pack_status(input logic dready, input logic ovr,
                                              input logic themp, input logic temt);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[USDP_STAT_DREADY]  = dready;
    w[USDP_STAT_OVERRUN] = ovr;
    w[USDP_STAT_THEMPTY] = themp;
    w[USDP_STAT_TEMT]    = temt;
    return w;
  endfunction : pack_status

  function automatic logic [3:0] pack_events(input logic ovr, input logic lost,
                                             input logic ready, input logic hold_em);
    logic [3:0] e;
    e = 4'h0;
    e[USDP_IRQ_OVERRUN] = ovr;
    e[USDP_IRQ_TXLOST]  = lost;
    e[USDP_IRQ_RXREADY] = ready;
    e[USDP_IRQ_THEMPTY] = hold_em;
    return e;
  endfunction : pack_events

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  function automatic logic is_data_addr(input logic [31:0] a);
    return (a == USDP_DATA_ADDR) ||
           (a >= USDP_SHADOW0_ADDR && a < USDP_SHADOW0_ADDR + 32'(4 * USDP_SHADOW_COUNT)
            && a[1:0] == 2'b00);
  endfunction : is_data_addr

  // Ring pointers wrap at the last slot, so a depth that is no power of two still works.
  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    return (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction : next_ptr

  wire req        = wb_req_i.cyc && wb_req_i.stb && !wb_ack_r;
  wire lane0      = wb_req_i.sel[0];
  wire data_hit   = is_data_addr(wb_req_i.adr);
  wire ctrl_hit   = wb_req_i.adr == USDP_CTRL_ADDR;
  wire status_hit = wb_req_i.adr == USDP_STATUS_ADDR;
  wire istat_hit  = wb_req_i.adr == USDP_IRQ_STAT_ADDR;
  wire imask_hit  = wb_req_i.adr == USDP_IRQ_MASK_ADDR;
  wire wr_data    = req && wb_req_i.we && data_hit && lane0;
  wire rd_data    = req && !wb_req_i.we && data_hit && lane0;
  wire wr_ctrl    = req && wb_req_i.we && ctrl_hit && lane0;
  wire wr_istat   = req && wb_req_i.we && istat_hit && lane0;
  wire wr_imask   = req && wb_req_i.we && imask_hit && lane0;
  wire rd_status  = req && !wb_req_i.we && status_hit;
  // A change of the FIFO enable bit flushes both paths so no stale character survives it; an IR mode change does not.
  wire mode_flip  = wr_ctrl && (wb_req_i.dat[USDP_CTRL_FIFO_EN] != fifo_en_r);

  ////////////////////////////////////////////////////////////////////////////
  // Receive side.
  wire usdp_char_s rx_in = ir_mode_r ? ir_rx_char_i : rx_char_i;
  wire rx_empty   = fifo_en_r ? (rx_cnt_r == '0) : !rx_full1_r;
  wire rx_full    = rx_cnt_r == FULL_CNT;
  wire rx_pop     = rd_data && !rx_empty;
  wire rx_push    = rx_in.valid && fifo_en_r && (!rx_full || rx_pop);
  wire rx_drop    = rx_in.valid && fifo_en_r && rx_full && !rx_pop;
  wire rx_ovwr    = rx_in.valid && !fifo_en_r && rx_full1_r && !rx_pop;
  wire [7:0] rx_head = fifo_en_r ? rx_mem[rx_rd_r] : rx_hold_r;
  wire data_ready = !rx_empty;
  wire [AW:0] rx_cnt_nxt = rx_cnt_r + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
  wire rx_full1_nxt = rx_in.valid || (rx_full1_r && !rx_pop);

  ////////////////////////////////////////////////////////////////////////////
  // Transmit side.
  wire tx_full    = tx_cnt_r == FULL_CNT;
  wire tx_empty   = fifo_en_r ? (tx_cnt_r == '0) : !tx_full1_r;
  wire tx_hold_em = tx_empty;
  wire tx_send    = tx_take_i && !tx_empty;
  wire tx_push    = wr_data && fifo_en_r && (!tx_full || tx_send);
  wire tx_lost    = wr_data && fifo_en_r && tx_full && !tx_send;
  wire [7:0] tx_head = fifo_en_r ? tx_mem[tx_rd_r] : tx_hold_r;
  wire [AW:0] tx_cnt_nxt = tx_cnt_r + (AW+1)'(tx_push) - (AW+1)'(tx_send);
  wire tx_full1_nxt = wr_data || (tx_full1_r && !tx_send);
  // A flush drops only the strobe; the last character stays on the data lines.
  wire tx_fire    = tx_send && !mode_flip;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; reserved bits read zero.
  wire [31:0] status_word = pack_status(data_ready, overrun_r, tx_hold_em,
                                        tx_hold_em && !tx_out_r.valid);
  wire [31:0] rd_val =
    data_hit   ? {24'h00_0000, rx_head} :
    ctrl_hit   ? pack_ctrl(fifo_en_r, ir_mode_r) :
    status_hit ? status_word :
    istat_hit  ? {28'h000_0000, irq_stat_r} :
    imask_hit  ? {28'h000_0000, irq_mask_r} :
    32'h0000_0000;
  // Read data is zero outside the answer so a stale word is never mistaken for a fresh one.
  wire [31:0] wb_dat_nxt = (req && !wb_req_i.we) ? rd_val : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events.
  // Level events re-set while they hold, so clearing a live level does not stick.
  wire [3:0] irq_ev       = pack_events(rx_drop || rx_ovwr, tx_lost, data_ready, tx_hold_em);
  // Set wins over a write-one clear in the same cycle.
  wire [3:0] irq_clr      = wr_istat ? wb_req_i.dat[3:0] : 4'h0;
  wire [3:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_ev;
  // Overrun clears on a status read, but a new overrun wins.
  wire       overrun_nxt  = rx_drop || rx_ovwr || (overrun_r && !rd_status);

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
    end else begin
      wb_ack_r <= req;
      wb_dat_r <= wb_dat_nxt;
    end
  end

  // Control register and its registered copy on the mode pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_en_r   <= 1'b0;
      ir_mode_r   <= 1'b0;
      ir_mode_o_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        fifo_en_r <= wb_req_i.dat[USDP_CTRL_FIFO_EN];
        ir_mode_r <= wb_req_i.dat[USDP_CTRL_IR_MODE];
      end
      ir_mode_o_r <= ir_mode_r;
    end
  end

  // Interrupt and overrun state; the interrupt pin lags its status by one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= USDP_IRQ_RESET;
      irq_stat_r <= USDP_IRQ_RESET;
      overrun_r  <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      if (wr_imask) begin
        irq_mask_r <= wb_req_i.dat[3:0];
      end
      irq_stat_r <= irq_stat_nxt;
      overrun_r  <= overrun_nxt;
      irq_r      <= |(irq_stat_r & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer and FIFO.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_rd_r    <= '0;
      rx_wr_r    <= '0;
      rx_cnt_r   <= '0;
      rx_hold_r  <= USDP_CHAR_RESET;
      rx_full1_r <= 1'b0;
    end else if (mode_flip) begin
      rx_rd_r    <= '0;
      rx_wr_r    <= '0;
      rx_cnt_r   <= '0;
      rx_full1_r <= 1'b0;
    end else if (fifo_en_r) begin
      if (rx_push) begin
        rx_mem[rx_wr_r] <= rx_in.data;
        rx_wr_r         <= next_ptr(rx_wr_r);
      end
      if (rx_pop) begin
        rx_rd_r <= next_ptr(rx_rd_r);
      end
      rx_cnt_r <= rx_cnt_nxt;
    end else begin
      if (rx_in.valid) begin
        rx_hold_r <= rx_in.data;
      end
      rx_full1_r <= rx_full1_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding register and FIFO.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_rd_r    <= '0;
      tx_wr_r    <= '0;
      tx_cnt_r   <= '0;
      tx_hold_r  <= USDP_CHAR_RESET;
      tx_full1_r <= 1'b0;
    end else if (mode_flip) begin
      tx_rd_r    <= '0;
      tx_wr_r    <= '0;
      tx_cnt_r   <= '0;
      tx_full1_r <= 1'b0;
    end else if (fifo_en_r) begin
      if (tx_push) begin
        tx_mem[tx_wr_r] <= wb_req_i.dat[USDP_CHAR_MSB:0];
        tx_wr_r         <= next_ptr(tx_wr_r);
      end
      if (tx_send) begin
        tx_rd_r <= next_ptr(tx_rd_r);
      end
      tx_cnt_r <= tx_cnt_nxt;
    end else begin
      if (wr_data) begin
        tx_hold_r <= wb_req_i.dat[USDP_CHAR_MSB:0];
      end
      tx_full1_r <= tx_full1_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line-side output register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_out_r <= '0;
    end else begin
      tx_out_r.valid <= tx_fire;
      if (tx_fire) begin
        tx_out_r.data <= tx_head;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign wb_dat_o  = wb_dat_r;
  assign wb_ack_o  = wb_ack_r;
  assign tx_char_o = tx_out_r;
  assign ir_mode_o = ir_mode_o_r;
  assign irq_o     = irq_r;

endmodule : usdp_top

// File: tb/usdp_chk.sv
// Checker of the shadow data port bus answers and line handshakes.
module usdp_chk
  import usdp_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire usdp_pkg::usdp_wb_req_s wb_req_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire usdp_pkg::usdp_char_s   rx_char_i,
  input wire usdp_pkg::usdp_char_s   ir_rx_char_i,
  input wire logic                   tx_take_i,
  input wire usdp_pkg::usdp_char_s   tx_char_o,
  input wire logic                   ir_mode_o,
  input wire logic                   irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take_w = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  ////////////////////////////////////////////////////////////////////////////////
  property p_ack_one; take_w |=> wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack missing");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; wb_ack_o |-> $past(wb_req_i.cyc && wb_req_i.stb); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
  property p_upper_zero; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
  property p_tx_take; tx_char_o.valid |-> $past(tx_take_i); endproperty
  a_tx_take: assert property (p_tx_take) else $error("char sent untaken");
  property p_tx_hold; $changed(tx_char_o.data) |-> tx_char_o.valid; endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx data moved");
  property p_ir_mode; $changed(ir_mode_o) |-> $past(wb_ack_o); endproperty
  a_ir_mode: assert property (p_ir_mode) else $error("mode moved");
  c_read: cover property (wb_ack_o && !$past(wb_req_i.we));
  c_tx: cover property (tx_char_o.valid);
  c_irq: cover property (irq_o);
endmodule : usdp_chk
bind usdp_top usdp_chk #(.DEPTH(DEPTH)) usdp_chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_char_i(rx_char_i),
  .ir_rx_char_i(ir_rx_char_i), .tx_take_i(tx_take_i), .tx_char_o(tx_char_o),
  .ir_mode_o(ir_mode_o), .irq_o(irq_o));

// File: tb/usdp_line_model.sv
// Remote line partner: feeds received characters and drains sent ones.
module usdp_line_model
  import usdp_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 slow_i,
  input  wire usdp_pkg::usdp_char_s tx_i,
  output usdp_pkg::usdp_char_s      rx_o,
  output usdp_pkg::usdp_char_s      ir_o,
  output logic                      take_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  initial begin
    rx_o = '0;
    ir_o = '0;
  end
  assign take_o = !slow_i;
  // A released line shows the inverse of its last data, so stale values never match.
  task automatic send(input logic [7:0] b, input logic ir);
    @(posedge clk_i);
    if (ir) ir_o <= {1'b1, b};
    else rx_o <= {1'b1, b};
    @(posedge clk_i);
    ir_o <= {1'b0, ~ir_o.data};
    rx_o <= {1'b0, ~rx_o.data};
  endtask : send
  always @(posedge clk_i) if (tx_i.valid === 1'b1) got.push_back(tx_i.data);
endmodule : usdp_line_model

// File: tb/uart_shadow_data_port_tb_top.sv
// Self-checking bench for the shadow data port.
module uart_shadow_data_port_tb_top
  import usdp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEPTH = 4;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         slow  = 1'b1;
  usdp_wb_req_s req   = '0;
  usdp_char_s   rx_c, ir_c, tx_c;
  logic [31:0]  dat, d;
  logic         ack, take, ir_mode, irq;
  int           miscompares = 0;
  int           cmp_count = 0;
  always #20 clk_i = ~clk_i;
  usdp_top #(.DEPTH(DEPTH)) usdp_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_dat_o(dat), .wb_ack_o(ack), .rx_char_i(rx_c), .ir_rx_char_i(ir_c),
    .tx_take_i(take), .tx_char_o(tx_c), .ir_mode_o(ir_mode), .irq_o(irq));
  usdp_line_model usdp_line_model_i (.clk_i(clk_i), .slow_i(slow), .tx_i(tx_c),
    .rx_o(rx_c), .ir_o(ir_c), .take_o(take));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= {1'b1, 1'b1, we, 4'hf, a, v};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    d = dat;
    if (n >= 50) miscompares++;
    req <= '0;
  endtask : wb
  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string n);
    wb(1'b0, a, 32'h0);
    chk(n, d & m, e);
  endtask : rd
  task automatic drain(input int k);
    for (int n = 0; n < 100 && usdp_line_model_i.got.size() < k; n++) @(posedge clk_i);
  endtask : drain
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(USDP_DATA_ADDR, 32'hffff_ffff, 32'h0, "data reset");
    rd(USDP_SHADOW6_ADDR, 32'hffff_ffff, 32'h0, "alias reset");
    wb(1'b1, USDP_CTRL_ADDR, 32'h0);
    usdp_line_model_i.send(8'hA5, 1'b0);
    usdp_line_model_i.send(8'h3C, 1'b0);
    rd(USDP_STATUS_ADDR, 32'h3, 32'h3, "overrun");
    rd(USDP_SHADOW5_ADDR, 32'hffff_ffff, 32'h3C, "overwrite");
    wb(1'b1, USDP_CTRL_ADDR, 32'h2);
    usdp_line_model_i.send(8'h5A, 1'b1);
    rd(USDP_STATUS_ADDR, 32'h1, 32'h1, "ir ready");
    rd(USDP_SHADOW0_ADDR, 32'hffff_ffff, 32'h5A, "ir char");
    chk("ir mode", {31'h0, ir_mode}, 32'h1);
    wb(1'b1, USDP_CTRL_ADDR, 32'h1);
    for (int i = 0; i <= DEPTH; i++) usdp_line_model_i.send(8'h10 + 8'(i), 1'b0);
    rd(USDP_STATUS_ADDR, 32'h2, 32'h2, "fifo overrun");
    for (int i = 0; i < DEPTH; i++) begin
      rd(USDP_SHADOW0_ADDR + 32'(20 * i), 32'hff, 32'h10 + 32'(i), "head");
    end
    rd(USDP_STATUS_ADDR, 32'h1, 32'h0, "drained");
    wb(1'b1, USDP_CTRL_ADDR, 32'h0);
    usdp_line_model_i.got.delete();
    rd(USDP_STATUS_ADDR, 32'h20, 32'h20, "empty");
    wb(1'b1, USDP_SHADOW5_ADDR, 32'h41);
    rd(USDP_STATUS_ADDR, 32'h20, 32'h0, "not empty");
    wb(1'b1, USDP_DATA_ADDR, 32'h42);
    slow <= 1'b0;
    drain(2);
    chk("sent", 32'(usdp_line_model_i.got.size()), 32'h1);
    chk("held", {24'h0, usdp_line_model_i.got[0]}, 32'h42);
    slow <= 1'b1;
    wb(1'b1, USDP_CTRL_ADDR, 32'h1);
    wb(1'b1, USDP_IRQ_STAT_ADDR, 32'hf);
    usdp_line_model_i.got.delete();
    for (int i = 0; i <= DEPTH; i++) wb(1'b1, USDP_SHADOW0_ADDR + 32'(4 * i), 32'h60 + 32'(i));
    rd(USDP_IRQ_STAT_ADDR, 32'h2, 32'h2, "lost");
    chk("irq masked", {31'h0, irq}, 32'h0);
    wb(1'b1, USDP_IRQ_MASK_ADDR, 32'h2);
    @(posedge clk_i);
    chk("irq up", {31'h0, irq}, 32'h1);
    wb(1'b1, USDP_IRQ_STAT_ADDR, 32'h2);
    rd(USDP_IRQ_MASK_ADDR, 32'hf, 32'h2, "mask");
    chk("irq down", {31'h0, irq}, 32'h0);
    slow <= 1'b0;
    drain(DEPTH + 1);
    chk("queued", 32'(usdp_line_model_i.got.size()), 32'(DEPTH));
    foreach (usdp_line_model_i.got[i]) begin
      chk("tx char", {24'h0, usdp_line_model_i.got[i]}, 32'h60 + 32'(i));
    end
    wrap_up();
  end
endmodule : uart_shadow_data_port_tb_top
